// ---- common/iq_nco_regs_pkg.sv ----
// register map, field layout and reset values of the correction/mixer slice
package iq_nco_regs_pkg;

    // ------------------------------------------------------------------
    // bus widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] I_GAIN_OFS      = 8'h0C;
    localparam logic [ADDR_W-1:0] Q_GAIN_OFS      = 8'h0D;
    localparam logic [ADDR_W-1:0] PHASE_CORR_OFS  = 8'h10;
    localparam logic [ADDR_W-1:0] RSVD_A_OFS      = 8'h11;
    localparam logic [ADDR_W-1:0] PHASE_SHIFT_OFS = 8'h12;
    localparam logic [ADDR_W-1:0] RSVD_B_OFS      = 8'h13;
    localparam logic [ADDR_W-1:0] FREQ_LO_OFS     = 8'h14;
    localparam logic [ADDR_W-1:0] FREQ_HI_OFS     = 8'h15;
    localparam logic [ADDR_W-1:0] CORR_SYNC_OFS   = 8'h1E;
    localparam logic [ADDR_W-1:0] MIX_SYNC_OFS    = 8'h1F;
    localparam logic [ADDR_W-1:0] STATUS_OFS      = 8'h20;

    // ------------------------------------------------------------------
    // field widths and positions
    // ------------------------------------------------------------------
    localparam int GAIN_W          = 11;
    localparam int GAIN_FRAC       = 10;
    localparam int PHASE_CORR_W    = 12;
    localparam int PHASE_CORR_FRAC = 12;
    localparam int PHASE_HOLD_W    = 14;
    localparam int PHASE_SHIFT_W   = 16;
    localparam int FREQ_W          = 32;
    localparam int SYNC_EN_BIT     = 0;
    localparam int STAT_QMC_BIT    = 0;
    localparam int STAT_MIX_BIT    = 1;
    localparam int LUT_BITS        = 4;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [GAIN_W-1:0]        GAIN_RST        = 11'h400;
    localparam logic [PHASE_HOLD_W-1:0]  PHASE_CORR_RST  = 14'h0000;
    localparam logic [PHASE_SHIFT_W-1:0] PHASE_SHIFT_RST = 16'h0000;
    localparam logic [FREQ_W-1:0]        FREQ_RST        = 32'h0000_0000;
    localparam logic                     SYNC_EN_RST     = 1'b0;

endpackage

// ---- rtl/iq_phase_gain_corrector.sv ----
// quadrature phase and gain correction datapath
`timescale 1ns/10ps
module iq_phase_gain_corrector #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic                                         clk_sys,
    input  wire logic                                         rst,
    // samples in
    input  wire logic signed [W-1:0]                          samp_a,
    input  wire logic signed [W-1:0]                          samp_b,
    // active settings
    input  wire logic [iq_nco_regs_pkg::GAIN_W-1:0]           i_gain,
    input  wire logic [iq_nco_regs_pkg::GAIN_W-1:0]           q_gain,
    input  wire logic signed [iq_nco_regs_pkg::PHASE_CORR_W-1:0] phase_corr,
    // corrected samples
    output logic signed [W-1:0]                               corr_i,
    output logic signed [W-1:0]                               corr_q
);
    import iq_nco_regs_pkg::*;

    localparam int PW = W + PHASE_CORR_W;

    logic signed [PW-1:0]         pb_prod;
    logic signed [W+1:0]          a_ph;
    logic signed [W+GAIN_W+2:0]   i_scaled;
    logic signed [W+GAIN_W:0]     q_scaled;
    logic signed [31:0]           i_wide;
    logic signed [31:0]           q_wide;

    function automatic logic signed [W-1:0] sat(input logic signed [31:0] v);
        logic signed [31:0] hi;
        logic signed [31:0] lo;
        hi = 32'(signed'({1'b0, {(W-1){1'b1}}}));
        lo = -hi - 32'sd1;
        if (v > hi) begin
            sat = hi[W-1:0];
        end else if (v < lo) begin
            sat = lo[W-1:0];
        end else begin
            sat = v[W-1:0];
        end
    endfunction

    // phase word is a fraction of 2^12, so -0.5 .. 0.49975
    assign pb_prod  = samp_b * phase_corr;
    assign a_ph     = {{2{samp_a[W-1]}}, samp_a}
                    + {{2{pb_prod[PW-1]}}, pb_prod[PW-1:PHASE_CORR_FRAC]};
    // gains are unsigned with ten fraction bits
    assign i_scaled = a_ph * $signed({1'b0, i_gain});
    assign q_scaled = samp_b * $signed({1'b0, q_gain});
    assign i_wide   = 32'(i_scaled >>> GAIN_FRAC);
    assign q_wide   = 32'(q_scaled >>> GAIN_FRAC);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            corr_i <= '0;
            corr_q <= '0;
        end else begin
            corr_i <= sat(i_wide);
            corr_q <= sat(q_wide);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    unity_pass_a: assert property (
        (i_gain == GAIN_RST && q_gain == GAIN_RST && phase_corr == '0)
        |=> (corr_i == $past(samp_a) && corr_q == $past(samp_b)))
        else $error("unity gain and zero phase must pass samples");

    half_phase_a: assert property (
        (i_gain == GAIN_RST && phase_corr == 12'h800
         && samp_b == 16'h0002 && samp_a != 16'h8000)
        |=> (corr_i == $past(samp_a) - 16'sd1))
        else $error("phase term not added into A sample");

endmodule // iq_phase_gain_corrector

// ---- rtl/nco_phase_lookup.sv ----
// oscillator accumulator, phase offset and sine/cosine lookup
`timescale 1ns/10ps
module nco_phase_lookup (
    // clock and reset
    input  wire logic                                        clk_sys,
    input  wire logic                                        rst,
    // active settings
    input  wire logic [iq_nco_regs_pkg::FREQ_W-1:0]          freq_word,
    input  wire logic [iq_nco_regs_pkg::PHASE_SHIFT_W-1:0]   phase_shift,
    // outputs
    output logic [iq_nco_regs_pkg::PHASE_SHIFT_W-1:0]        phase_index,
    output logic signed [15:0]                               nco_sin,
    output logic signed [15:0]                               nco_cos
);
    import iq_nco_regs_pkg::*;

    // coarse table: the index top bits address one sine period
    localparam logic [15:0] SINE_LUT [16] = '{
        16'h0000, 16'h30FB, 16'h5A82, 16'h7641,
        16'h7FFF, 16'h7641, 16'h5A82, 16'h30FB,
        16'h0000, 16'hCF05, 16'hA57E, 16'h89BF,
        16'h8001, 16'h89BF, 16'hA57E, 16'hCF05
    };
    localparam logic [LUT_BITS-1:0] QUARTER = 4'h4;

    logic [FREQ_W-1:0]        acc_r;
    logic [PHASE_SHIFT_W-1:0] idx;
    logic [LUT_BITS-1:0]      sin_sel;
    logic [LUT_BITS-1:0]      cos_sel;

    // offset joins the upper half of the accumulator
    assign idx     = acc_r[FREQ_W-1 -: PHASE_SHIFT_W] + phase_shift;
    assign sin_sel = idx[PHASE_SHIFT_W-1 -: LUT_BITS];
    assign cos_sel = sin_sel + QUARTER;

    // wraps modulo 2^32, so a negative word steps backwards
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_r <= '0;
        end else begin
            acc_r <= acc_r + freq_word;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase_index <= '0;
            nco_sin     <= '0;
            nco_cos     <= '0;
        end else begin
            phase_index <= idx;
            nco_sin     <= signed'(SINE_LUT[sin_sel]);
            nco_cos     <= signed'(SINE_LUT[cos_sel]);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    offset_add_a: assert property (
        1'b1 |=> (phase_index
                  == $past(acc_r[FREQ_W-1 -: PHASE_SHIFT_W] + phase_shift)))
        else $error("phase index is not accumulator plus offset");

    acc_step_a: assert property (
        $stable(freq_word) |=> (acc_r == $past(acc_r) + $past(freq_word)))
        else $error("accumulator did not advance by the frequency word");

endmodule // nco_phase_lookup

// ---- rtl/iq_phase_nco_offset_shadow_regs.sv ----
// holding/active register bank for IQ phase correction and NCO offset
//
// What this block does
// - phase-correction field is 12-bit two's complement, -0.5 to 0.49975; the holding copy keeps and reads back 14 bits
// - phase value times B sample is added into the A sample
// - phase-correction field resets to zero, no correction applied
// - with correction sync enabled, writing offset 0x10 fires a sync
// - that sync loads both gains and phase into the datapath together
// - gain writes only change holding copies until a sync transfer
// - 16-bit offset is added to upper accumulator half before lookup
// - offset-adjusted 16-bit phase indexes the sine and cosine tables
// - with mixer sync enabled, writing offset 0x12 fires a sync
// - mixer sync loads offset and both frequency halves together
// - frequency-word writes leave the active mixer untouched until sync
// - 11-bit gains are unsigned, point between bits 9 and 10
// - 32-bit frequency word is two's complement, step Fs over 2^32
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
module iq_phase_nco_offset_shadow_regs #(
    parameter int SAMP_W = 16
) (
    // clock and reset
    input  wire logic                                   clk_sys,
    input  wire logic                                   rst,
    // register port
    input  wire logic [iq_nco_regs_pkg::ADDR_W-1:0]     reg_addr,
    input  wire logic [iq_nco_regs_pkg::DATA_W-1:0]     reg_wr_data,
    input  wire logic                                   reg_wr,
    input  wire logic                                   reg_rd,
    output logic [iq_nco_regs_pkg::DATA_W-1:0]          reg_rd_data,
    // other synchronisation sources
    input  wire logic                                   qmc_ext_sync,
    input  wire logic                                   mix_ext_sync,
    // sample path
    input  wire logic signed [SAMP_W-1:0]               samp_a,
    input  wire logic signed [SAMP_W-1:0]               samp_b,
    output logic signed [SAMP_W-1:0]                    corr_i,
    output logic signed [SAMP_W-1:0]                    corr_q,
    // oscillator
    output logic [iq_nco_regs_pkg::PHASE_SHIFT_W-1:0]   phase_index,
    output logic signed [15:0]                          nco_sin,
    output logic signed [15:0]                          nco_cos,
    // active settings
    output logic [iq_nco_regs_pkg::GAIN_W-1:0]          i_channel_gain,
    output logic [iq_nco_regs_pkg::GAIN_W-1:0]          q_channel_gain,
    output logic [iq_nco_regs_pkg::PHASE_CORR_W-1:0]    phase_corr_active,
    output logic [iq_nco_regs_pkg::PHASE_SHIFT_W-1:0]   phase_shift_active,
    output logic [iq_nco_regs_pkg::FREQ_W-1:0]          freq_word_active
);
    import iq_nco_regs_pkg::*;

    localparam int HALF_W = FREQ_W / 2;

    // ------------------------------------------------------------------
    // holding copies and enables
    // ------------------------------------------------------------------
    logic [GAIN_W-1:0]        i_gain_hold_r;
    logic [GAIN_W-1:0]        q_gain_hold_r;
    logic [PHASE_HOLD_W-1:0]  phase_corr_hold_r;
    logic [PHASE_SHIFT_W-1:0] phase_shift_hold_r;
    logic [FREQ_W-1:0]        freq_hold_r;
    logic                     corr_sync_en_r;
    logic                     mix_sync_en_r;

    logic [GAIN_W-1:0]        i_gain_nxt;
    logic [GAIN_W-1:0]        q_gain_nxt;
    logic [PHASE_HOLD_W-1:0]  phase_corr_nxt;
    logic [PHASE_SHIFT_W-1:0] phase_shift_nxt;
    logic [FREQ_W-1:0]        freq_nxt;

    logic                     wr_i_gain;
    logic                     wr_q_gain;
    logic                     wr_phase_corr;
    logic                     wr_phase_shift;
    logic                     wr_freq_lo;
    logic                     wr_freq_hi;
    logic                     qmc_sync;
    logic                     mix_sync;
    logic                     qmc_differs;
    logic                     mix_differs;
    logic [DATA_W-1:0]        rd_mux;

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    assign wr_i_gain      = reg_wr && (reg_addr == I_GAIN_OFS);
    assign wr_q_gain      = reg_wr && (reg_addr == Q_GAIN_OFS);
    assign wr_phase_corr  = reg_wr && (reg_addr == PHASE_CORR_OFS);
    assign wr_phase_shift = reg_wr && (reg_addr == PHASE_SHIFT_OFS);
    assign wr_freq_lo     = reg_wr && (reg_addr == FREQ_LO_OFS);
    assign wr_freq_hi     = reg_wr && (reg_addr == FREQ_HI_OFS);

    // holding values as they stand after this cycle's write; a sync in
    // the same cycle as the trigger write must carry the new word
    assign i_gain_nxt = wr_i_gain ? reg_wr_data[GAIN_W-1:0]
                                  : i_gain_hold_r;
    assign q_gain_nxt = wr_q_gain ? reg_wr_data[GAIN_W-1:0]
                                  : q_gain_hold_r;
    assign phase_corr_nxt = wr_phase_corr
                          ? reg_wr_data[PHASE_HOLD_W-1:0]
                          : phase_corr_hold_r;
    assign phase_shift_nxt = wr_phase_shift ? reg_wr_data
                                            : phase_shift_hold_r;
    assign freq_nxt = {wr_freq_hi ? reg_wr_data : freq_hold_r[FREQ_W-1:HALF_W],
                       wr_freq_lo ? reg_wr_data : freq_hold_r[HALF_W-1:0]};

    // ------------------------------------------------------------------
    // sync sources
    // ------------------------------------------------------------------
    assign qmc_sync = (wr_phase_corr && corr_sync_en_r)
                    || qmc_ext_sync;
    assign mix_sync = (wr_phase_shift && mix_sync_en_r)
                    || mix_ext_sync;

    // ------------------------------------------------------------------
    // holding registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            i_gain_hold_r     <= GAIN_RST;
            q_gain_hold_r     <= GAIN_RST;
            phase_corr_hold_r <= PHASE_CORR_RST;
        end else begin
            i_gain_hold_r     <= i_gain_nxt;
            q_gain_hold_r     <= q_gain_nxt;
            phase_corr_hold_r <= phase_corr_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase_shift_hold_r <= PHASE_SHIFT_RST;
            freq_hold_r        <= FREQ_RST;
        end else begin
            phase_shift_hold_r <= phase_shift_nxt;
            freq_hold_r        <= freq_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            corr_sync_en_r <= SYNC_EN_RST;
            mix_sync_en_r  <= SYNC_EN_RST;
        end else begin
            if (reg_wr && reg_addr == CORR_SYNC_OFS) begin
                corr_sync_en_r <= reg_wr_data[SYNC_EN_BIT];
            end
            if (reg_wr && reg_addr == MIX_SYNC_OFS) begin
                mix_sync_en_r <= reg_wr_data[SYNC_EN_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // active settings, loaded all at once on a sync
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            i_channel_gain    <= GAIN_RST;
            q_channel_gain    <= GAIN_RST;
            phase_corr_active <= PHASE_CORR_RST[PHASE_CORR_W-1:0];
        end else if (qmc_sync) begin
            i_channel_gain    <= i_gain_nxt;
            q_channel_gain    <= q_gain_nxt;
            phase_corr_active <= phase_corr_nxt[PHASE_CORR_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase_shift_active <= PHASE_SHIFT_RST;
            freq_word_active   <= FREQ_RST;
        end else if (mix_sync) begin
            phase_shift_active <= phase_shift_nxt;
            freq_word_active   <= freq_nxt;
        end
    end

    // ------------------------------------------------------------------
    // readback: holding copies, enables and a pending-transfer status
    // ------------------------------------------------------------------
    // status shows holding and active disagree, i.e. a sync is still owed
    assign qmc_differs = (i_gain_hold_r != i_channel_gain)
                      || (q_gain_hold_r != q_channel_gain)
                      || (phase_corr_hold_r[PHASE_CORR_W-1:0]
                          != phase_corr_active);
    assign mix_differs = (phase_shift_hold_r != phase_shift_active)
                      || (freq_hold_r != freq_word_active);

    always_comb begin
        rd_mux = '0;
        case (reg_addr)
            I_GAIN_OFS: begin
                rd_mux[GAIN_W-1:0] = i_gain_hold_r;
            end
            Q_GAIN_OFS: begin
                rd_mux[GAIN_W-1:0] = q_gain_hold_r;
            end
            PHASE_CORR_OFS: begin
                rd_mux[PHASE_HOLD_W-1:0] = phase_corr_hold_r;
            end
            PHASE_SHIFT_OFS: begin
                rd_mux = phase_shift_hold_r;
            end
            FREQ_LO_OFS: begin
                rd_mux = freq_hold_r[HALF_W-1:0];
            end
            FREQ_HI_OFS: begin
                rd_mux = freq_hold_r[FREQ_W-1:HALF_W];
            end
            CORR_SYNC_OFS: begin
                rd_mux[SYNC_EN_BIT] = corr_sync_en_r;
            end
            MIX_SYNC_OFS: begin
                rd_mux[SYNC_EN_BIT] = mix_sync_en_r;
            end
            STATUS_OFS: begin
                rd_mux[STAT_QMC_BIT] = qmc_differs;
                rd_mux[STAT_MIX_BIT] = mix_differs;
            end
            // factory slots and unmapped addresses read as zero
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rd_data <= '0;
        end else if (reg_rd) begin
            reg_rd_data <= rd_mux;
        end else begin
            reg_rd_data <= '0;
        end
    end

    // ------------------------------------------------------------------
    // datapaths
    // ------------------------------------------------------------------
    iq_phase_gain_corrector #(
        .W (SAMP_W)
    ) u_corrector (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .samp_a     (samp_a),
        .samp_b     (samp_b),
        .i_gain     (i_channel_gain),
        .q_gain     (q_channel_gain),
        .phase_corr (signed'(phase_corr_active)),
        .corr_i     (corr_i),
        .corr_q     (corr_q)
    );

    nco_phase_lookup u_nco (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .freq_word   (freq_word_active),
        .phase_shift (phase_shift_active),
        .phase_index (phase_index),
        .nco_sin     (nco_sin),
        .nco_cos     (nco_cos)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    phase_reset_zero_a: assert property (disable iff (1'b0)
        rst |=> (phase_corr_active == '0 && phase_corr_hold_r == '0))
        else $error("phase correction not zero after reset");

    qmc_auto_sync_a: assert property (
        (wr_phase_corr && corr_sync_en_r)
        |=> (phase_corr_active == $past(reg_wr_data[PHASE_CORR_W-1:0])))
        else $error("phase write with sync enabled did not load");

    qmc_together_a: assert property (
        qmc_sync |=> (i_channel_gain == i_gain_hold_r
                      && q_channel_gain == q_gain_hold_r
                      && phase_corr_active
                         == phase_corr_hold_r[PHASE_CORR_W-1:0]))
        else $error("correction values not moved together");

    gain_hold_only_a: assert property (
        ((wr_i_gain || wr_q_gain) && !qmc_ext_sync)
        |=> ($stable(i_channel_gain) && $stable(q_channel_gain)))
        else $error("gain write changed active gain");

    mix_auto_sync_a: assert property (
        (wr_phase_shift && mix_sync_en_r)
        |=> (phase_shift_active == $past(reg_wr_data)))
        else $error("offset write with sync enabled did not load");

    mix_together_a: assert property (
        mix_sync |=> (freq_word_active == freq_hold_r
                      && phase_shift_active == phase_shift_hold_r))
        else $error("mixer values not moved together");

    freq_hold_only_a: assert property (
        ((wr_freq_lo || wr_freq_hi) && !mix_ext_sync)
        |=> $stable(freq_word_active))
        else $error("frequency write changed active mixer");

    no_auto_sync_a: assert property (
        (wr_phase_corr && !corr_sync_en_r && !qmc_ext_sync)
        ##1 (!qmc_sync)[*2]
        |-> $stable(phase_corr_active) && $past(phase_corr_active, 2)
            == phase_corr_active)
        else $error("phase loaded without a sync source");

    read_slot_a: assert property (
        !reg_rd |=> (reg_rd_data == '0))
        else $error("read data outside the read slot");

endmodule // iq_phase_nco_offset_shadow_regs

// ---- dv/tb_top.sv ----
// self-checking bench for the correction and mixer holding registers
`timescale 1ns/10ps
module tb_top;
    import iq_nco_regs_pkg::*;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic                      clk_sys = 1'b0;
    logic                      rst = 1'b1;
    logic [ADDR_W-1:0]         reg_addr = '0;
    logic [DATA_W-1:0]         reg_wr_data = '0;
    logic                      reg_wr = 1'b0;
    logic                      reg_rd = 1'b0;
    logic [DATA_W-1:0]         reg_rd_data;
    logic                      qmc_ext_sync = 1'b0;
    logic                      mix_ext_sync = 1'b0;
    logic signed [15:0]        samp_a = 16'sh0123;
    logic signed [15:0]        samp_b = 16'sh0456;
    logic signed [15:0]        corr_i, corr_q, nco_sin, nco_cos;
    logic [PHASE_SHIFT_W-1:0]  phase_index, phase_shift_active, p0;
    logic [GAIN_W-1:0]         i_channel_gain, q_channel_gain;
    logic [PHASE_CORR_W-1:0]   phase_corr_active;
    logic [FREQ_W-1:0]         freq_word_active;
    int                        n_errors = 0;
    int                        tests_run = 0;

    always #25 clk_sys = ~clk_sys;

    iq_phase_nco_offset_shadow_regs #(
        .SAMP_W(16)
    ) u_iq_phase_nco_offset_shadow_regs (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rd_data(reg_rd_data), .qmc_ext_sync(qmc_ext_sync),
        .mix_ext_sync(mix_ext_sync), .samp_a(samp_a), .samp_b(samp_b),
        .corr_i(corr_i), .corr_q(corr_q), .phase_index(phase_index),
        .nco_sin(nco_sin), .nco_cos(nco_cos),
        .i_channel_gain(i_channel_gain), .q_channel_gain(q_channel_gain),
        .phase_corr_active(phase_corr_active),
        .phase_shift_active(phase_shift_active),
        .freq_word_active(freq_word_active));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // wait n edges, then sample on the falling edge where all is settled
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk("reg_rd_data", {16'h0000, exp}, {16'h0000, reg_rd_data});
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // hang guard: the sequence needs well under 300 cycles
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_errors++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        rd(PHASE_CORR_OFS, 16'h0000);
        chk("phase_corr_active", 32'h0, phase_corr_active);
        // zero phase and unity gains pass the idle samples untouched
        chk("corr_i", 32'h0123, {16'h0000, corr_i});
        chk("corr_q", 32'h0456, {16'h0000, corr_q});
        // a zero offset on a cleared accumulator sits at angle zero
        chk("nco_sin", 32'h0, {16'h0000, nco_sin});
        chk("nco_cos", 32'h7FFF, {16'h0000, nco_cos});
        wr(I_GAIN_OFS, 16'h0200);
        wr(PHASE_CORR_OFS, 16'hF800);
        rd(PHASE_CORR_OFS, 16'h3800);
        rd(STATUS_OFS, 16'h0001);
        chk("i_channel_gain", 32'h400, i_channel_gain);
        chk("phase_corr_active", 32'h0, phase_corr_active);
        wr(RSVD_A_OFS, 16'hFFFF);
        rd(RSVD_A_OFS, 16'h0000);
        @(posedge clk_sys);
        qmc_ext_sync <= 1'b1;
        @(posedge clk_sys);
        qmc_ext_sync <= 1'b0;
        tick(1);
        chk("i_channel_gain", 32'h200, i_channel_gain);
        chk("phase_corr_active", 32'h800, phase_corr_active);
        wr(CORR_SYNC_OFS, 16'h0001);
        wr(I_GAIN_OFS, 16'h0400);
        wr(Q_GAIN_OFS, 16'hF300);
        rd(Q_GAIN_OFS, 16'h0300);
        wr(PHASE_CORR_OFS, 16'h3800);
        samp_a <= 16'sh2000;
        samp_b <= 16'sh1000;
        tick(2);
        chk("i_channel_gain", 32'h400, i_channel_gain);
        chk("q_channel_gain", 32'h300, q_channel_gain);
        // half-scale negative phase pulls half of b out of a
        chk("corr_i", 32'h1800, {16'h0000, corr_i});
        chk("corr_q", 32'h0C00, {16'h0000, corr_q});
        @(posedge clk_sys);
        samp_b <= 16'sh0002;
        tick(2);
        // the phase product is floored, so a tiny b still takes one
        chk("corr_i", 32'h1FFF, {16'h0000, corr_i});
        wr(FREQ_LO_OFS, 16'h0001);
        wr(FREQ_HI_OFS, 16'h0001);
        wr(PHASE_SHIFT_OFS, 16'h1234);
        tick(1);
        chk("freq_word_active", 32'h0, freq_word_active);
        chk("phase_shift_active", 32'h0, phase_shift_active);
        rd(STATUS_OFS, 16'h0002);
        @(posedge clk_sys);
        mix_ext_sync <= 1'b1;
        @(posedge clk_sys);
        mix_ext_sync <= 1'b0;
        tick(1);
        chk("freq_word_active", 32'h0001_0001, freq_word_active);
        chk("phase_shift_active", 32'h1234, phase_shift_active);
        // accumulator was still zero when this index was formed, so the index is the offset alone
        chk("phase_index", 32'h1234, {16'h0, phase_index});
        // top nibble one is a sixteenth of a turn
        chk("nco_sin", 32'h30FB, {16'h0000, nco_sin});
        chk("nco_cos", 32'h7641, {16'h0000, nco_cos});
        wr(MIX_SYNC_OFS, 16'h0001);
        wr(FREQ_HI_OFS, 16'h0002);
        tick(0);
        chk("freq_word_active", 32'h0001_0001, freq_word_active);
        wr(PHASE_SHIFT_OFS, 16'h2345);
        tick(2);
        chk("freq_word_active", 32'h0002_0001, freq_word_active);
        chk("phase_shift_active", 32'h2345, phase_shift_active);
        rd(PHASE_SHIFT_OFS, 16'h2345);
        rd(RSVD_B_OFS, 16'h0000);
        p0 = phase_index;
        tick(0);
        tick(1);
        // a step of 2^17 moves the upper accumulator half by two
        chk("phase_index", {16'h0, p0 + 16'h0004}, {16'h0, phase_index});
        print_verdict();
    end
endmodule // tb_top
